// ---- common/lbf_pkg.sv ----
// Purpose: Shared constants and types of the lamp brightness supervisor.
// Assumes: A 20 MHz system clock.
// Notes: Operation
// Operation
// - Ambient brightness from 8-bit light code.
// - Light code clamped to low/high limits.
// - Effective brightness never below ten percent.
// - Light code sampled once per dimming period.
// - 256 levels, one code is 0.391 percent.
// - Duty mode follows input duty, ten percent floor.
// - Bus mode follows brightness register, ten percent floor.
// - Light brightness scaled by input duty.
// - Register brightness scaled by duty; 0x80 half.
// - Low lamp current advances timer slowly.
// - Timer trip latches fault, lamp drive stops.
// - Fault clears by lamp bit or power.
// - Overvoltage enables strong compensation discharge.
// - Low-side overcurrent switches high side off.
// - Sustained on-phase undervoltage shuts device down.
// - Secondary short discharges, advances timer fast.
// - Reset clears fault and restores registers.
// - Lockout disables both switch drivers.
// - Source bit ignored in ambient mode.
// - Brightness writes only in bus mode.
// - Control bit 0 enables or shuts down.
// - Target answers only its 7-bit address.
package lbf_pkg;
  localparam logic [6:0] SMB_DEV_ADDR = 7'h2c;
  localparam logic [2:0] REG_BRIGHT   = 3'h0;
  localparam logic [2:0] REG_CTRL     = 3'h1;
  localparam logic [2:0] REG_STAT     = 3'h2;
  localparam logic [2:0] REG_ID       = 3'h3;
  localparam logic [2:0] REG_ALS      = 3'h4;
  localparam logic [2:0] REG_ALS_LO   = 3'h5;
  localparam logic [2:0] REG_ALS_HI   = 3'h6;
  localparam logic [2:0] REG_LAST     = 3'h6;
  localparam logic [7:0] BRIGHT_RST   = 8'hff;
  localparam logic [5:0] CTRL_RST     = 6'h00;
  localparam logic [7:0] ALS_CODE_RST = 8'h00;
  localparam logic [7:0] ALS_LO_RST   = 8'h00;
  localparam logic [7:0] ALS_HI_RST   = 8'hff;
  // Identification value is arbitrary.
  localparam logic [7:0] ID_CODE      = 8'h5a;
  localparam int CTL_LAMP  = 0;
  localparam int CTL_SRC   = 1;
  localparam int CTL_ABS   = 2;
  localparam int CTL_LIGHT = 3;
  localparam int ST_FAULT  = 0;
  localparam int ST_OVC    = 2;
  localparam int ST_LAMP   = 3;
  localparam int FL_LOW_A  = 0;
  localparam int FL_LOW_B  = 1;
  localparam int FL_OV     = 2;
  localparam int FL_UV     = 3;
  localparam int FL_SHORT  = 4;
  localparam int FL_OC     = 5;
  localparam int FL_LS     = 6;
  localparam int FL_UNDERVOLTAGE_LOCKOUT   = 7;
  localparam logic [7:0] BRIGHT_FLOOR = 8'h1a;
  localparam int CLK_HZ         = 20_000_000;
  localparam int DIM_HZ         = 210;
  localparam int DIM_LEVELS     = 256;
  localparam int DIM_STEP_CYC   = CLK_HZ / (DIM_HZ * DIM_LEVELS);
  localparam int UV_DELAY_US    = 250;
  localparam int UV_DELAY_CYC   = UV_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int LAMPOUT_STEP   = 1;
  localparam int SHORT_STEP     = 135;
  localparam int FAULT_TRIP_DEF = 4_000_000;
  localparam int DUTY_WIN_LOG2  = 14;
  typedef enum logic [3:0] {
    SMB_IDLE, SMB_ADDR, SMB_AACK, SMB_CMD, SMB_CACK,
    SMB_WDATA, SMB_DACK, SMB_RDATA, SMB_RACK
  } lbf_smb_e;
endpackage

// ---- common/lbf_reg_if.sv ----
// Purpose: Register access path between bus target and register file.
// Assumes: Writes are one-cycle strobes.
// Notes: Read data is combinational from the register file.
`timescale 1ns/1ns
interface lbf_reg_if;
  logic       wr_stb;
  logic [2:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  modport master (output wr_stb, addr, wr_data, input rd_data);
  modport target (input wr_stb, addr, wr_data, output rd_data);
endinterface // lbf_reg_if

// ---- rtl/lbf_duty_meter.sv ----
// Purpose: Measures the duty fraction of the duty input.
// Assumes: Input period well below the averaging window.
// Notes: Code 0xff means fully high.
`timescale 1ns/1ns
module lbf_duty_meter
  import lbf_pkg::*;
#(
  parameter int WIN_LOG2 = DUTY_WIN_LOG2
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       duty_input,
  output logic      [7:0] duty_code
);
  typedef struct packed {
    logic [1:0]          s;
    logic [WIN_LOG2-1:0] win;
    logic [WIN_LOG2:0]   hi;
    logic [7:0]          code;
  } lbf_meter_s;

  lbf_meter_s st, next_st;

  always_comb begin
    logic [WIN_LOG2:0] tot;
    tot = st.hi + (WIN_LOG2+1)'(st.s[1]);
    next_st     = st;
    next_st.s   = {st.s[0], duty_input};
    next_st.win = st.win + 1'b1;
    next_st.hi  = tot;
    if (&st.win) begin
      next_st.hi   = '0;
      next_st.code = tot[WIN_LOG2] ? 8'hff : tot[WIN_LOG2-1 -: 8];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign duty_code = st.code;
endmodule // lbf_duty_meter

// ---- rtl/lbf_smbus_slave.sv ----
// Purpose: Two-wire bus target for byte write and byte read.
// Assumes: Bus clock far slower than the system clock.
// Notes: A write is committed at the stop or repeated start.
`timescale 1ns/1ns
module lbf_smbus_slave
  import lbf_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  lbf_reg_if.master bus
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_d;
    logic       sda_d;
    lbf_smb_e   st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic       rw;
    logic [2:0] cmd;
    logic [7:0] wdata;
    logic       wpend;
    logic       drv;
    logic       wr;
  } lbf_smb_s;

  lbf_smb_s st, next_st;
  logic scl, sda, rise, fall, start, stop;

  always_comb begin
    scl   = st.scl_s[1];
    sda   = st.sda_s[1];
    rise  = scl & ~st.scl_d;
    fall  = ~scl & st.scl_d;
    start = scl & st.scl_d & st.sda_d & ~sda;
    stop  = scl & st.scl_d & ~st.sda_d & sda;
    next_st       = st;
    next_st.wr    = 1'b0;
    next_st.scl_s = {st.scl_s[0], scl_in};
    next_st.sda_s = {st.sda_s[0], sda_in};
    next_st.scl_d = scl;
    next_st.sda_d = sda;
    if (start || stop) begin
      next_st.wr    = st.wpend;
      next_st.wpend = 1'b0;
      next_st.drv   = 1'b0;
      next_st.bitc  = 4'h0;
      next_st.st    = start ? SMB_ADDR : SMB_IDLE;
    end else if (rise) begin
      next_st.bitc = st.bitc + 4'h1;
      if (st.st inside {SMB_ADDR, SMB_CMD, SMB_WDATA}) begin
        next_st.sh = {st.sh[6:0], sda};
      end
      if (st.st == SMB_RACK) begin
        next_st.st = SMB_IDLE;
      end
    end else if (fall) begin
      unique case (st.st)
        SMB_ADDR: if (st.bitc == 4'h8) begin
          if (st.sh[7:1] == SMB_DEV_ADDR) begin
            next_st.drv = 1'b1;
            next_st.rw  = st.sh[0];
            next_st.st  = SMB_AACK;
          end else begin
            next_st.st = SMB_IDLE;
          end
        end
        SMB_AACK: begin
          next_st.bitc = 4'h0;
          if (st.rw) begin
            next_st.sh  = bus.rd_data;
            next_st.drv = ~bus.rd_data[7];
            next_st.st  = SMB_RDATA;
          end else begin
            next_st.drv = 1'b0;
            next_st.st  = SMB_CMD;
          end
        end
        SMB_CMD: if (st.bitc == 4'h8) begin
          if (st.sh <= {5'h00, REG_LAST}) begin
            next_st.drv = 1'b1;
            next_st.cmd = st.sh[2:0];
            next_st.st  = SMB_CACK;
          end else begin
            next_st.st = SMB_IDLE;
          end
        end
        SMB_CACK: begin
          next_st.drv  = 1'b0;
          next_st.bitc = 4'h0;
          next_st.st   = SMB_WDATA;
        end
        SMB_WDATA: if (st.bitc == 4'h8) begin
          next_st.drv   = 1'b1;
          next_st.wdata = st.sh;
          next_st.wpend = 1'b1;
          next_st.st    = SMB_DACK;
        end
        SMB_DACK: begin
          next_st.drv = 1'b0;
          next_st.st  = SMB_IDLE;
        end
        SMB_RDATA: if (st.bitc == 4'h8) begin
          next_st.drv = 1'b0;
          next_st.st  = SMB_RACK;
        end else begin
          next_st.sh  = {st.sh[6:0], 1'b0};
          next_st.drv = ~st.sh[6];
        end
        SMB_IDLE, SMB_RACK: begin
        end
        default: next_st.st = SMB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // Edge detectors start at the idle-high bus level.
      st <= '{scl_s: 2'b11, sda_s: 2'b11, scl_d: 1'b1, sda_d: 1'b1,
              st: SMB_IDLE, default: '0};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign bus.wr_stb  = st.wr;
  assign bus.addr    = st.cmd;
  assign bus.wr_data = st.wdata;
  assign sda_out     = 1'b0;
  assign sda_oe_n    = ~st.drv;
endmodule // lbf_smbus_slave

// ---- rtl/lbf_lamp_supervisor.sv ----
// Purpose: Brightness selection, dimming chopper and fault supervision.
// Assumes: Comparator results arrive as asynchronous flags.
// Notes: Registers are reached only over the two-wire bus.
`timescale 1ns/1ns
module lbf_lamp_supervisor
  import lbf_pkg::*;
#(
  parameter int FAULT_TRIP = FAULT_TRIP_DEF,
  parameter int UV_DELAY   = UV_DELAY_CYC,
  parameter int DIM_STEP   = DIM_STEP_CYC
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic [7:0] ambient_light_input,
  input  wire logic       duty_input,
  input  wire logic       lamp_current_feedback_a_low,
  input  wire logic       lamp_current_feedback_b_low,
  input  wire logic       secondary_voltage_feedback_over,
  input  wire logic       secondary_voltage_feedback_under,
  input  wire logic       secondary_current_sense_over,
  input  wire logic       switch_node_overcurrent,
  input  wire logic       low_side_on,
  input  wire logic       undervoltage_lockout,
  output logic            dimming_chopper,
  output logic            bridge_drive_enable,
  output logic            high_side_block,
  output logic            comp_discharge_strong,
  output logic            regulator_full_output,
  output logic            fault_latched
);
  localparam int TRIP_W = $clog2(FAULT_TRIP + SHORT_STEP + 1);
  localparam int UV_W   = $clog2(UV_DELAY + 1);
  localparam int STEP_W = $clog2(DIM_STEP + 1);

  typedef struct packed {
    logic [7:0]        fl_s1;
    logic [7:0]        fl_s2;
    logic [7:0]        als_s1;
    logic [7:0]        als_s2;
    logic [7:0]        bright;
    logic [5:0]        ctrl;
    logic [7:0]        als_lo;
    logic [7:0]        als_hi;
    logic [7:0]        als_code;
    logic [7:0]        level;
    logic [STEP_W-1:0] step;
    logic [7:0]        phase;
    logic [TRIP_W-1:0] fault_delay_timer;
    logic [UV_W-1:0]   uv_cnt;
    logic              fault;
    logic              drive;
    logic              drv_en;
    logic              hs_blk;
    logic              comp_dis;
  } lbf_sup_s;

  lbf_sup_s   st;
  lbf_sup_s   next_st;
  logic [7:0] flags;
  logic [7:0] duty_code;
  logic [7:0] als_clamp;
  logic [7:0] raw;
  logic [7:0] target;
  logic       bus_mode;
  logic       run;
  logic       on_phase;
  logic       last_step;
  logic       period_end;
  logic       lamp_low;

  lbf_reg_if bus_if ();

  lbf_smbus_slave u_bus (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe_n (sda_oe_n),
    .bus      (bus_if)
  );

  lbf_duty_meter #(
    .WIN_LOG2 (DUTY_WIN_LOG2)
  ) u_duty (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .ce         (ce),
    .duty_input (duty_input),
    .duty_code  (duty_code)
  );

  // Scales a brightness code by a duty code; 0xff duty is unity.
  function automatic logic [7:0] scale(input logic [7:0] a,
                                       input logic [7:0] d);
    logic [16:0] p;
    p = 17'(a) * 17'({1'b0, d} + 9'h001);
    return p[15:8];
  endfunction

  assign flags = {undervoltage_lockout, low_side_on,
                  switch_node_overcurrent, secondary_current_sense_over,
                  secondary_voltage_feedback_under,
                  secondary_voltage_feedback_over,
                  lamp_current_feedback_b_low,
                  lamp_current_feedback_a_low};

  // Brightness source selection.
  always_comb begin
    if (st.als_code < st.als_lo) begin
      als_clamp = st.als_lo;
    end else if (st.als_code > st.als_hi) begin
      als_clamp = st.als_hi;
    end else begin
      als_clamp = st.als_code;
    end
    bus_mode = ~st.ctrl[CTL_LIGHT] & ~st.ctrl[CTL_SRC];
    if (st.ctrl[CTL_LIGHT]) begin
      raw = st.ctrl[CTL_ABS] ? als_clamp : scale(als_clamp, duty_code);
    end else if (st.ctrl[CTL_SRC]) begin
      raw = duty_code;
    end else begin
      raw = st.ctrl[CTL_ABS] ? st.bright : scale(st.bright, duty_code);
    end
    target = (raw < BRIGHT_FLOOR) ? BRIGHT_FLOOR : raw;
  end

  // Register read mux.
  always_comb begin
    unique case (bus_if.addr)
      REG_BRIGHT: bus_if.rd_data = st.bright;
      REG_CTRL:   bus_if.rd_data = {2'b00, st.ctrl};
      REG_STAT:   bus_if.rd_data = {4'h0, ~lamp_low,
                                    st.fl_s2[FL_OC], 1'b0, st.fault};
      REG_ID:     bus_if.rd_data = ID_CODE;
      REG_ALS:    bus_if.rd_data = st.als_code;
      REG_ALS_LO: bus_if.rd_data = st.als_lo;
      REG_ALS_HI: bus_if.rd_data = st.als_hi;
      default:    bus_if.rd_data = 8'h00;
    endcase
  end

  always_comb begin
    run        = st.ctrl[CTL_LAMP] & ~st.fault & ~st.fl_s2[FL_UNDERVOLTAGE_LOCKOUT];
    on_phase   = st.phase <= st.level;
    last_step  = st.step == STEP_W'(DIM_STEP - 1);
    period_end = last_step && (st.phase == 8'hff);
    lamp_low   = st.fl_s2[FL_LOW_A] | st.fl_s2[FL_LOW_B];
    next_st        = st;
    next_st.fl_s1  = flags;
    next_st.fl_s2  = st.fl_s1;
    next_st.als_s1 = ambient_light_input;
    next_st.als_s2 = st.als_s1;
    next_st.step   = last_step ? '0 : st.step + 1'b1;
    if (last_step) begin
      next_st.phase = st.phase + 8'h01;
    end
    if (period_end) begin
      // A light code still changing waits for the next period.
      if (st.als_s2 == st.als_s1) begin
        next_st.als_code = st.als_s2;
      end
      next_st.level    = target;
    end
    if (bus_if.wr_stb) begin
      unique case (bus_if.addr)
        REG_BRIGHT: if (bus_mode) begin
          next_st.bright = bus_if.wr_data;
        end
        REG_CTRL:   next_st.ctrl   = bus_if.wr_data[5:0];
        REG_ALS_LO: next_st.als_lo = bus_if.wr_data;
        REG_ALS_HI: next_st.als_hi = bus_if.wr_data;
        default: begin
        end
      endcase
    end
    if (!run) begin
      next_st.fault_delay_timer   = '0;
      next_st.uv_cnt = '0;
    end else begin
      if (st.fl_s2[FL_SHORT]) begin
        next_st.fault_delay_timer = st.fault_delay_timer + TRIP_W'(SHORT_STEP);
      end else if (on_phase && lamp_low) begin
        next_st.fault_delay_timer = st.fault_delay_timer + TRIP_W'(LAMPOUT_STEP);
      end else begin
        next_st.fault_delay_timer = '0;
      end
      if (st.fault_delay_timer >= TRIP_W'(FAULT_TRIP)) begin
        next_st.fault = 1'b1;
      end
      if (on_phase && st.fl_s2[FL_UV]) begin
        next_st.uv_cnt = st.uv_cnt + 1'b1;
        if (st.uv_cnt == UV_W'(UV_DELAY - 1)) begin
          next_st.fault = 1'b1;
        end
      end else begin
        next_st.uv_cnt = '0;
      end
    end
    if (!st.ctrl[CTL_LAMP]) begin
      next_st.fault = 1'b0;
    end
    next_st.drive    = run & on_phase;
    next_st.drv_en   = run;
    next_st.hs_blk   = run & st.fl_s2[FL_LS] & st.fl_s2[FL_OC];
    next_st.comp_dis = run & (st.fl_s2[FL_OV] | st.fl_s2[FL_SHORT]);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '{bright: BRIGHT_RST, ctrl: CTRL_RST, als_code: ALS_CODE_RST,
              als_lo: ALS_LO_RST, als_hi: ALS_HI_RST,
              level: BRIGHT_FLOOR, default: '0};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign dimming_chopper       = st.drive;
  assign bridge_drive_enable   = st.drv_en;
  assign high_side_block       = st.hs_blk;
  assign comp_discharge_strong = st.comp_dis;
  assign regulator_full_output = st.ctrl[CTL_LAMP];
  assign fault_latched         = st.fault;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence period_end_s;
    ce && period_end && st.als_s2 == st.als_s1;
  endsequence

  sequence uv_last_s;
    ce && run && on_phase && st.fl_s2[FL_UV] &&
      st.uv_cnt == UV_W'(UV_DELAY - 1);
  endsequence

  sequence trip_s;
    ce && run && st.fault_delay_timer >= TRIP_W'(FAULT_TRIP);
  endsequence

  lockout_off_a: assert property (
    ce && st.fl_s2[FL_UNDERVOLTAGE_LOCKOUT] |=> !bridge_drive_enable && !dimming_chopper)
    else $error("Drivers enabled during lockout.");

  fault_clear_a: assert property (
    ce && !st.ctrl[CTL_LAMP] |=> !fault_latched)
    else $error("Fault latch not cleared by lamp bit.");

  bright_guard_a: assert property (
    ce && bus_if.wr_stb && bus_if.addr == REG_BRIGHT && !bus_mode
      |=> $stable(st.bright))
    else $error("Brightness written outside bus mode.");

  level_floor_a: assert property (
    st.level >= BRIGHT_FLOOR)
    else $error("Brightness level below floor.");

  timer_trip_a: assert property (
    trip_s |=> fault_latched ##1 !dimming_chopper)
    else $error("Timer trip did not shut the lamp.");

  uv_shut_a: assert property (
    uv_last_s |=> fault_latched)
    else $error("Undervoltage delay did not shut down.");

  hs_cut_a: assert property (
    ce && run && st.fl_s2[FL_LS] && st.fl_s2[FL_OC] |=> high_side_block)
    else $error("High side not blocked on overcurrent.");

  ov_discharge_a: assert property (
    ce && run && st.fl_s2[FL_OV] |=> comp_discharge_strong)
    else $error("No strong discharge on overvoltage.");

  als_sample_a: assert property (
    period_end_s |=> st.als_code == $past(st.als_s2))
    else $error("Light code not sampled at period end.");

  short_rate_a: assert property (
    ce && run && st.fl_s2[FL_SHORT] && st.fault_delay_timer < TRIP_W'(FAULT_TRIP)
      |=> st.fault_delay_timer == $past(st.fault_delay_timer) + TRIP_W'(SHORT_STEP))
    else $error("Short did not advance timer at fast rate.");
endmodule // lbf_lamp_supervisor

// ---- tb/lbf_host_model.sv ----
// Purpose: Two-wire bus host that reaches the block registers.
// Assumes: The data wire is pulled up and any party may pull it low.
// Notes: The high half of each bus clock lasts eight system clocks, the low half nine.
`timescale 1ns/1ns
module lbf_host_model
  import lbf_pkg::*;
(
  input  wire logic clock,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_oe_n
);
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic half();
    repeat (8) @(posedge clock);
  endtask
  task automatic start();
    @(posedge clock) sda_oe_n <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_oe_n <= 1'b0;
    half();
    scl <= 1'b0;
  endtask
  task automatic stop();
    @(posedge clock) sda_oe_n <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_oe_n <= 1'b1;
    half();
  endtask
  task automatic bit_io(input logic b, output logic s);
    @(posedge clock) sda_oe_n <= b;
    half();
    scl <= 1'b1;
    half();
    s = sda_wire;
    scl <= 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
                         output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [2:0] c,
                           input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k1, k2, k3;
    start();
    byte_io({a, 1'b0}, q, k1);
    byte_io({5'h00, c}, q, k2);
    byte_io(d, q, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic read_reg(input logic [2:0] c, output logic [7:0] d,
                          output logic ok);
    logic [7:0] q;
    logic k1, k2, k3, k4;
    start();
    byte_io({SMB_DEV_ADDR, 1'b0}, q, k1);
    byte_io({5'h00, c}, q, k2);
    start();
    byte_io({SMB_DEV_ADDR, 1'b1}, q, k3);
    byte_io(8'hff, d, k4);
    stop();
    ok = k1 & k2 & k3;
  endtask
endmodule // lbf_host_model

// ---- tb/tb_lbf_lamp_supervisor.sv ----
// Purpose: Self-checking bench of the lamp brightness supervisor.
// Assumes: Shortened trip, delay and step counts.
// Notes: Brightness is measured as on-clocks over one dimming period.
`timescale 1ns/1ns
module tb_lbf_lamp_supervisor
  import lbf_pkg::*;
();
  localparam int TRIP = 300;
  localparam int UVD  = 20;
  localparam int STEP = 2;
  logic       clock, sys_rst, scl, host_oe_n, sda_oe_n, sda_wire;
  logic       duty_input, dimming_chopper, bridge_drive_enable;
  logic       high_side_block, comp_discharge_strong;
  logic       regulator_full_output, fault_latched, ok, ce, sda_out;
  logic [8:0] ph = 9'h000;
  logic [7:0] amb, flg, ctrl;
  logic [7:0] bv [4] = '{8'hff, 8'h80, 8'h00, 8'h00};
  logic [7:0] av [3] = '{8'h10, 8'hf0, 8'h00};
  int         fi [3], fmin [3], fmax [3];
  int         br, lo, hi, dc, pw, t, bad_count, comparisons;
  assign sda_wire = host_oe_n & (sda_oe_n | sda_out);
  lbf_host_model host (.clock(clock), .sda_wire(sda_wire), .scl(scl),
                       .sda_oe_n(host_oe_n));
  lbf_lamp_supervisor #(.FAULT_TRIP(TRIP), .UV_DELAY(UVD),
                        .DIM_STEP(STEP)) DUT (
    .clock(clock), .sys_rst(sys_rst), .ce(ce), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .ambient_light_input(amb), .duty_input(duty_input),
    .lamp_current_feedback_a_low(flg[FL_LOW_A]),
    .lamp_current_feedback_b_low(flg[FL_LOW_B]),
    .secondary_voltage_feedback_over(flg[FL_OV]),
    .secondary_voltage_feedback_under(flg[FL_UV]),
    .secondary_current_sense_over(flg[FL_SHORT]),
    .switch_node_overcurrent(flg[FL_OC]), .low_side_on(flg[FL_LS]),
    .undervoltage_lockout(flg[FL_UNDERVOLTAGE_LOCKOUT]),
    .dimming_chopper(dimming_chopper),
    .bridge_drive_enable(bridge_drive_enable),
    .high_side_block(high_side_block),
    .comp_discharge_strong(comp_discharge_strong),
    .regulator_full_output(regulator_full_output),
    .fault_latched(fault_latched));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    ph <= ph + 9'h001;
    duty_input <= ph < pw;
  end
  task automatic summarize();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] c, input logic [7:0] d);
    host.write_reg(SMB_DEV_ADDR, c, d, ok);
    check("write ack", 1, ok);
    repeat (8) @(posedge clock);
  endtask
  task automatic rd(input logic [2:0] c, input logic [7:0] e);
    logic [7:0] d;
    host.read_reg(c, d, ok);
    check("read ack", 1, ok);
    check("read data", e, d);
  endtask
  function automatic int level(input logic [7:0] c);
    int a;
    if (c[CTL_LIGHT]) a = amb < lo ? lo : (amb > hi ? hi : amb);
    else if (c[CTL_SRC]) a = dc;
    else a = br;
    if (!c[CTL_ABS] && (c[CTL_LIGHT] || !c[CTL_SRC])) a = (a * (dc + 1)) >> 8;
    return a < int'(BRIGHT_FLOOR) ? int'(BRIGHT_FLOOR) : a;
  endfunction
  task automatic bright(input logic [7:0] c);
    int n;
    n = 0;
    ctrl = c;
    wr(REG_CTRL, c);
    repeat (1100) @(posedge clock);
    repeat (256 * STEP) @(posedge clock) n += int'(dimming_chopper);
    check("on clocks", STEP * (level(c) + 1), n);
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    bad_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'hbaa2));
    {sys_rst, ce, amb, flg, ctrl} = {2'b11, 8'h00, 8'h00, 8'h00};
    {br, lo, hi, dc} = {32'd255, 32'd0, 32'd255, 32'd255};
    fi = '{FL_LOW_B, FL_SHORT, FL_UV};
    fmin = '{TRIP - 1, 2, UVD - 2};
    fmax = '{TRIP + 10, 10, UVD + 10};
    bv[3] = 8'($urandom);
    av[2] = 8'($urandom);
    pw = $urandom % 512;
    dc = pw / 2;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    rd(REG_BRIGHT, 8'hff);
    rd(REG_CTRL, 8'h00);
    rd(REG_ALS, 8'h00);
    rd(REG_ALS_LO, 8'h00);
    rd(REG_ALS_HI, 8'hff);
    rd(REG_ID, ID_CODE);
    host.write_reg(7'h2d, 3'h0, 8'h11, ok);
    check("foreign address ack", 0, ok);
    host.write_reg(SMB_DEV_ADDR, 3'h7, 8'h11, ok);
    check("unmapped ack", 0, ok);
    $display("test registers done");
    foreach (bv[i]) begin
      br = bv[i];
      wr(REG_BRIGHT, bv[i]);
      bright(8'h05);
      rd(REG_BRIGHT, bv[i]);
    end
    $display("test bus brightness done");
    wr(REG_CTRL, 8'h0f);
    wr(REG_BRIGHT, 8'h40);
    rd(REG_BRIGHT, 8'(br));
    {lo, hi} = {32'h30, 32'hc0};
    wr(REG_ALS_LO, 8'h30);
    wr(REG_ALS_HI, 8'hc0);
    foreach (av[i]) begin
      amb <= av[i];
      bright(8'h0f);
      rd(REG_ALS, av[i]);
    end
    lo = 5;
    amb <= 8'h02;
    wr(REG_ALS_LO, 8'h05);
    bright(8'h0f);
    amb <= av[2];
    $display("test light mode done");
    bright(8'h03);
    bright(8'h01);
    bright(8'h09);
    pw = 0;
    dc = 0;
    repeat (2 ** (DUTY_WIN_LOG2 + 1)) @(posedge clock);
    bright(8'h03);
    bright(8'h01);
    bright(8'h09);
    $display("test duty scaling done");
    br = 255;
    wr(REG_CTRL, 8'h05);
    wr(REG_BRIGHT, 8'hff);
    repeat (1100) @(posedge clock);
    flg[FL_OV] <= 1'b1;
    repeat (5) @(posedge clock);
    check("strong discharge", 1, comp_discharge_strong);
    {flg[FL_OV], flg[FL_OC], flg[FL_LS]} <= 3'b011;
    repeat (5) @(posedge clock);
    check("high side block", 1, high_side_block);
    flg[FL_LS] <= 1'b0;
    repeat (5) @(posedge clock);
    check("high side free", 0, high_side_block);
    {flg[FL_OC], flg[FL_UNDERVOLTAGE_LOCKOUT]} <= 2'b01;
    repeat (5) @(posedge clock);
    check("lockout drive", 0, bridge_drive_enable);
    flg[FL_UNDERVOLTAGE_LOCKOUT] <= 1'b0;
    repeat (5) @(posedge clock);
    check("drive back", 1, bridge_drive_enable);
    foreach (fi[i]) begin
      t = 0;
      flg[fi[i]] <= 1'b1;
      while (fault_latched !== 1'b1 && t < 2000) begin
        @(posedge clock);
        t++;
      end
      check("trip in range", 1, t >= fmin[i] && t <= fmax[i]);
      @(posedge clock);
      check("drive off", 0, {dimming_chopper, bridge_drive_enable});
      check("regulator", 1, regulator_full_output);
      flg[fi[i]] <= 1'b0;
      repeat (20) @(posedge clock);
      check("fault held", 1, fault_latched);
      rd(REG_STAT, 8'h09);
      wr(REG_CTRL, 8'h04);
      check("fault clear", 0, fault_latched);
      wr(REG_CTRL, 8'h05);
      check("restart", 1, bridge_drive_enable);
    end
    $display("test protection done");
    ce <= 1'b0;
    flg[FL_UNDERVOLTAGE_LOCKOUT] <= 1'b1;
    repeat (10) @(posedge clock);
    check("frozen drive", 1, bridge_drive_enable);
    ce <= 1'b1;
    repeat (5) @(posedge clock);
    check("lockout drive", 0, bridge_drive_enable);
    {flg[FL_UNDERVOLTAGE_LOCKOUT], flg[FL_SHORT]} <= 2'b01;
    repeat (20) @(posedge clock);
    check("short fault", 1, fault_latched);
    {sys_rst, flg[FL_SHORT]} <= 2'b10;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    check("reset fault", 0, fault_latched);
    rd(REG_CTRL, 8'h00);
    $display("test enable and reset done");
    summarize();
  end
endmodule // tb_lbf_lamp_supervisor
